// ### core/switch_monitor_supervisor.sv
// Notes on behaviour
// - Logic supply absent stops link, keeps registers.
// - Hold reset until supply release, then initialise.
// - After init raise interrupt and power-on flags.
// - Trim load, self-check; failure sets error flag.
// - Monitoring starts only once run bit set.
// - Running locks configuration except listed bits.
// - Checksum stays usable while monitoring runs.
// - Three reset sources all restore defaults.
// - Reset pin low is normal, high resets.
// - Reset pin high halts everything, clears registers.
// - Reset pin low again reinitialises, raises flags.
// - Software reset bit reinitialises with flag report.
// - Under-voltage entry stops currents and monitoring.
// - Under-voltage entry sets event, status, fault flag.
// - Frame end clears cause only if read.
// - Under-voltage keeps link, settings and status.
// - Under-voltage lasts until rise; single interrupt.
// - Under-voltage exit sets event, clears status.
// - Exit resumes polling from first channel.
// - First cycle after recovery sets baseline.
// - Supply below falling threshold fully resets.
`timescale 1ns/1ns
`include "supervisor_regs.svh"

module switch_monitor_supervisor
    import supervisor_pkg::*;
#(
    parameter int INIT_CYCLES = `INIT_TIME_US * `CLK_MHZ
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic vdd_ok_i,
    input wire logic reset_pin_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire supply_ind_type supply_i,
    input wire logic selfcheck_ok_i,
    input wire logic poll_cycle_done_i,
    input wire logic switch_change_i,
    output logic int_n_o,
    output logic wetting_en_o,
    output logic monitor_en_o,
    output logic link_en_o,
    output logic trim_load_o,
    output logic poll_restart_o,
    output logic baseline_load_o,
    output logic por_flag_o,
    output logic fault_flag_o
);

    generate
        if (INIT_CYCLES < 2 || INIT_CYCLES > 65535) begin : g_bad
            $error("INIT_CYCLES must lie in 2..65535");
        end
    endgenerate

    // Pin inputs pass two flip-flops before any logic looks at them.
    pin_bus_type pin_raw;
    logic [7:0] sync1_r;
    logic [7:0] sync2_r;
    pin_bus_type pin_s;

    assign pin_raw = {vdd_ok_i, reset_pin_i, cs_n_i, sclk_i, supply_i};

    for (genvar i = 0; i < 8; i++) begin : g_sync
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                sync1_r[i] <= 1'(`PINS_RST >> i);
                sync2_r[i] <= 1'(`PINS_RST >> i);
            end else if (ce_i) begin
                sync1_r[i] <= pin_raw[i];
                sync2_r[i] <= sync1_r[i];
            end
        end
    end

    assign pin_s = sync2_r;

    logic cs_prev_r;
    logic sclk_prev_r;
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cs_prev_r <= 1'b1;
            sclk_prev_r <= 1'b0;
        end else if (ce_i) begin
            cs_prev_r <= pin_s.cs_n;
            sclk_prev_r <= pin_s.sclk;
        end
    end

    assign cs_fall = cs_prev_r && !pin_s.cs_n;
    assign cs_rise = !cs_prev_r && pin_s.cs_n;
    assign sclk_rise = !sclk_prev_r && pin_s.sclk && !pin_s.cs_n;

    // Supply power-on reset holds from power-up until the release level.
    logic por_hold_r;
    logic swrst_r;
    logic hold;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            por_hold_r <= 1'b1;
        end else if (ce_i) begin
            if (pin_s.supply.por_fall) begin
                por_hold_r <= 1'b1;
            end else if (pin_s.supply.por_release) begin
                por_hold_r <= 1'b0;
            end
        end
    end

    assign hold = por_hold_r || pin_s.reset_pin || swrst_r;

    seq_state_type state_r;
    logic [15:0] init_cnt_r;
    logic init_done;
    logic check_fail;

    assign init_done = (state_r == ST_CHECK) && !hold;
    assign check_fail = init_done && !selfcheck_ok_i;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= ST_HOLD;
            init_cnt_r <= 16'h0000;
        end else if (ce_i) begin
            if (hold) begin
                state_r <= ST_HOLD;
                init_cnt_r <= 16'h0000;
            end else begin
                unique case (state_r)
                    ST_HOLD: begin
                        state_r <= ST_TRIM;
                    end
                    ST_TRIM: begin
                        init_cnt_r <= init_cnt_r + 16'h0001;
                        if (init_cnt_r == 16'(INIT_CYCLES - 1)) begin
                            state_r <= ST_CHECK;
                        end
                    end
                    ST_CHECK: begin
                        state_r <= ST_READY;
                    end
                    ST_READY: begin
                        state_r <= ST_READY;
                    end
                endcase
            end
        end
    end

    logic in_reset;
    logic link_ok;

    assign in_reset = (state_r == ST_HOLD);
    assign link_ok = pin_s.vdd_ok && !in_reset;

    // Classic Wishbone slave: one wait state, ack for one cycle.
    logic req;
    logic wr;
    logic rd;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i && link_ok;
    assign rd = req && !wb_we_i && link_ok;

    logic run_r;
    logic [7:0] ccp_r;
    logic [15:0] cfg_r;
    logic [7:0] crc_r;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            swrst_r <= 1'b0;
        end else if (ce_i) begin
            swrst_r <= wr && wb_sel_i[0] && (wb_adr_i == `ADDR_MAIN)
                && wb_dat_i[`MAIN_SW_RESET];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_r <= 1'b0;
            ccp_r <= `CCP_RST;
        end else if (ce_i) begin
            if (in_reset) begin
                run_r <= 1'b0;
                ccp_r <= `CCP_RST;
            end else if (wr && wb_sel_i[0]) begin
                if (wb_adr_i == `ADDR_MAIN) begin
                    run_r <= wb_dat_i[`MAIN_RUN];
                end
                if (wb_adr_i == `ADDR_CCP) begin
                    ccp_r <= wb_dat_i[7:0];
                end
            end
        end
    end

    // Configuration is read-only while monitoring runs.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_r <= `CFG_RST;
        end else if (ce_i) begin
            if (in_reset) begin
                cfg_r <= `CFG_RST;
            end else if (wr && !run_r && wb_adr_i == `ADDR_CFG) begin
                if (wb_sel_i[0]) begin
                    cfg_r[7:0] <= wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    cfg_r[15:8] <= wb_dat_i[15:8];
                end
            end
        end
    end

    // The checksum kick is honoured whatever the run bit says.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            crc_r <= 8'h00;
        end else if (ce_i) begin
            if (in_reset) begin
                crc_r <= 8'h00;
            end else if (wr && wb_sel_i[0] && wb_adr_i == `ADDR_MAIN
                && wb_dat_i[`MAIN_CRC_KICK]) begin
                crc_r <= cfg_r[15:8] ^ cfg_r[7:0] ^ ccp_r;
            end
        end
    end

    // Under-voltage: entry and exit come from separate levels for hysteresis.
    logic uv_low_r;
    logic uv_in;
    logic uv_out;

    assign uv_in = !in_reset && !uv_low_r && pin_s.supply.uv_enter;
    assign uv_out = !in_reset && uv_low_r && pin_s.supply.uv_exit;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            uv_low_r <= 1'b0;
        end else if (ce_i) begin
            if (in_reset) begin
                uv_low_r <= 1'b0;
            end else if (uv_in) begin
                uv_low_r <= 1'b1;
            end else if (uv_out) begin
                uv_low_r <= 1'b0;
            end
        end
    end

    logic mon_on;
    logic first_cycle_r;

    assign mon_on = run_r && !uv_low_r && (state_r == ST_READY);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            first_cycle_r <= 1'b0;
        end else if (ce_i) begin
            if (in_reset) begin
                first_cycle_r <= 1'b0;
            end else if (uv_out) begin
                first_cycle_r <= 1'b1;
            end else if (mon_on && poll_cycle_done_i) begin
                first_cycle_r <= 1'b0;
            end
        end
    end

    // Interrupt cause: a new event in the clearing cycle survives the clear.
    logic [`CAUSE_W-1:0] cause_r;
    logic [`CAUSE_W-1:0] cause_set;
    logic [`CAUSE_W-1:0] cause_nxt;
    logic cause_read_r;
    logic ssc_hit;

    assign ssc_hit = mon_on && ((first_cycle_r && poll_cycle_done_i)
        || (!first_cycle_r && switch_change_i));

    always_comb begin
        cause_set = '0;
        cause_set[`CAUSE_POR] = init_done;
        cause_set[`CAUSE_CHK] = check_fail;
        cause_set[`CAUSE_UV] = uv_in || uv_out;
        cause_set[`CAUSE_SSC] = ssc_hit;
        if (in_reset) begin
            cause_nxt = '0;
        end else if (cs_rise && cause_read_r) begin
            cause_nxt = cause_set;
        end else begin
            cause_nxt = cause_r | cause_set;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cause_r <= '0;
            int_n_o <= 1'b1;
        end else if (ce_i) begin
            cause_r <= cause_nxt;
            int_n_o <= ~(|cause_nxt);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cause_read_r <= 1'b0;
        end else if (ce_i) begin
            if (in_reset || cs_rise) begin
                cause_read_r <= 1'b0;
            end else if (rd && !pin_s.cs_n && wb_adr_i == `ADDR_CAUSE) begin
                cause_read_r <= 1'b1;
            end
        end
    end

    // Link clock edges counted per frame, reported in the status register.
    logic [7:0] bits_r;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bits_r <= 8'h00;
        end else if (ce_i) begin
            if (!link_ok || cs_fall) begin
                bits_r <= 8'h00;
            end else if (sclk_rise) begin
                bits_r <= bits_r + 8'h01;
            end
        end
    end

    logic [31:0] rdata;

    always_comb begin
        rdata = 32'h0000_0000;
        case (wb_adr_i)
            `ADDR_MAIN: rdata[`MAIN_RUN] = run_r;
            `ADDR_CCP: rdata[7:0] = ccp_r;
            `ADDR_CFG: rdata[15:0] = cfg_r;
            `ADDR_CAUSE: rdata[`CAUSE_W-1:0] = cause_r;
            `ADDR_STATUS: begin
                rdata[`STAT_UV_LOW] = uv_low_r;
                rdata[`STAT_MON] = mon_on;
                rdata[`STAT_LINK] = link_ok;
                rdata[`STAT_FAULT] = uv_low_r;
                rdata[`STAT_POR] = cause_r[`CAUSE_POR];
                rdata[`STAT_BITS_HI:`STAT_BITS_LO] = bits_r;
            end
            `ADDR_CRC: rdata[7:0] = crc_r;
            default: rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= req;
            if (rd) begin
                wb_dat_o <= rdata;
            end else if (req) begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wetting_en_o <= 1'b0;
            monitor_en_o <= 1'b0;
            link_en_o <= 1'b0;
            trim_load_o <= 1'b0;
            poll_restart_o <= 1'b0;
            baseline_load_o <= 1'b0;
            por_flag_o <= 1'b0;
            fault_flag_o <= 1'b0;
        end else if (ce_i) begin
            wetting_en_o <= mon_on;
            monitor_en_o <= mon_on;
            link_en_o <= link_ok;
            trim_load_o <= (state_r == ST_TRIM);
            poll_restart_o <= uv_out && run_r;
            baseline_load_o <= mon_on && first_cycle_r && poll_cycle_done_i;
            por_flag_o <= cause_nxt[`CAUSE_POR];
            fault_flag_o <= uv_low_r;
        end
    end

endmodule : switch_monitor_supervisor

// ### shared/supervisor_pkg.sv
package supervisor_pkg;

    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_TRIM = 2'b01,
        ST_CHECK = 2'b10,
        ST_READY = 2'b11
    } seq_state_type;

    typedef struct packed {
        logic por_release;
        logic por_fall;
        logic uv_enter;
        logic uv_exit;
    } supply_ind_type;

    typedef struct packed {
        logic vdd_ok;
        logic reset_pin;
        logic cs_n;
        logic sclk;
        supply_ind_type supply;
    } pin_bus_type;

endpackage : supervisor_pkg

// ### shared/supervisor_regs.svh
`ifndef SUPERVISOR_REGS_SVH
`define SUPERVISOR_REGS_SVH

// Register byte offsets.
`define ADDR_MAIN 8'h00
`define ADDR_CCP 8'h04
`define ADDR_CFG 8'h08
`define ADDR_CAUSE 8'h0c
`define ADDR_STATUS 8'h10
`define ADDR_CRC 8'h14

// Main setup register fields.
`define MAIN_RUN 0
`define MAIN_CRC_KICK 1
`define MAIN_SW_RESET 2

// Interrupt cause register fields.
`define CAUSE_POR 0
`define CAUSE_CHK 1
`define CAUSE_UV 2
`define CAUSE_SSC 3
`define CAUSE_W 4

// Status register fields.
`define STAT_UV_LOW 0
`define STAT_MON 1
`define STAT_LINK 2
`define STAT_FAULT 3
`define STAT_POR 4
`define STAT_BITS_LO 8
`define STAT_BITS_HI 15

// Reset values.
`define CFG_RST 16'h0000
`define CCP_RST 8'h00
`define PINS_RST 8'h20

// Timing.
`define CLK_MHZ 125
`define INIT_TIME_US 40

`endif

// ### tb/switch_host_model.sv
`timescale 1ns/1ns

module switch_host_model #(
    parameter int RST_MIN_CYC = 250
) (
    input wire logic clk_i,
    input wire logic frame_i,
    input wire logic reset_req_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic reset_pin_o
);
    int hold_cnt;

    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        reset_pin_o = 1'b0;
        hold_cnt = 0;
    end

    // The link clock only runs inside a frame and rests low between frames.
    always begin
        wait (frame_i === 1'b1);
        // Step off the clock edge so the pins never change where they are sampled.
        #2;
        cs_n_o = 1'b0;
        #200;
        while (frame_i === 1'b1) begin
            sclk_o = 1'b1;
            #80;
            sclk_o = 1'b0;
            #80;
        end
        #200;
        cs_n_o = 1'b1;
        #1600;
    end

    // A short request is stretched so the pin never stays high too briefly.
    always @(posedge clk_i) begin
        if (reset_req_i || (reset_pin_o && hold_cnt < RST_MIN_CYC)) begin
            reset_pin_o <= 1'b1;
            hold_cnt <= hold_cnt + 1;
        end else begin
            reset_pin_o <= 1'b0;
            hold_cnt <= 0;
        end
    end
endmodule : switch_host_model

// ### tb/switch_monitor_supervisor_chk.sv
`timescale 1ns/1ns

module switch_monitor_supervisor_chk #(
    parameter int INIT_CYCLES = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic vdd_ok_i,
    input wire logic reset_pin_i,
    input wire logic poll_cycle_done_i,
    input wire logic int_n_o,
    input wire logic wetting_en_o,
    input wire logic monitor_en_o,
    input wire logic link_en_o,
    input wire logic trim_load_o,
    input wire logic poll_restart_o,
    input wire logic baseline_load_o,
    input wire logic por_flag_o,
    input wire logic fault_flag_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_por_int;
        $rose(por_flag_o) |-> ##[0:1] !int_n_o;
    endproperty
    a_por_int: assert property (p_por_int) else $error("power-on flag without interrupt");
    property p_init_done;
        $fell(trim_load_o) && !reset_pin_i |-> ##[1:3] por_flag_o;
    endproperty
    a_init_done: assert property (p_init_done) else $error("no flag after trim load");
    property p_run_pair;
        monitor_en_o == wetting_en_o;
    endproperty
    a_run_pair: assert property (p_run_pair) else $error("wetting and monitor differ");
    property p_uv_stop;
        fault_flag_o && $past(fault_flag_o) |-> !monitor_en_o && !wetting_en_o;
    endproperty
    a_uv_stop: assert property (p_uv_stop) else $error("monitoring during low supply");
    property p_uv_int;
        $rose(fault_flag_o) |-> ##[0:2] !int_n_o;
    endproperty
    a_uv_int: assert property (p_uv_int) else $error("no interrupt on low supply");
    property p_uv_exit;
        $fell(fault_flag_o) && link_en_o |-> ##[0:2] !int_n_o;
    endproperty
    a_uv_exit: assert property (p_uv_exit) else $error("no interrupt on supply recovery");
    property p_pin_reset;
        reset_pin_i [*7] |-> !link_en_o && !monitor_en_o && int_n_o && !por_flag_o;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("reset pin did not halt");
    property p_vdd_off;
        !vdd_ok_i [*5] |-> !link_en_o;
    endproperty
    a_vdd_off: assert property (p_vdd_off) else $error("link alive without supply");
    property p_restart;
        poll_restart_o |-> ##1 (!fault_flag_o && !poll_restart_o);
    endproperty
    a_restart: assert property (p_restart) else $error("bad polling restart pulse");
    property p_baseline;
        baseline_load_o |-> $past(poll_cycle_done_i) ##1 !baseline_load_o;
    endproperty
    a_baseline: assert property (p_baseline) else $error("baseline not at poll end");

    c_por: cover property ($rose(por_flag_o));
    c_uv: cover property ($rose(fault_flag_o));
    c_restart: cover property (poll_restart_o);
    c_baseline: cover property (baseline_load_o);
endmodule : switch_monitor_supervisor_chk

bind switch_monitor_supervisor switch_monitor_supervisor_chk #(.INIT_CYCLES(INIT_CYCLES)) chk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .vdd_ok_i(vdd_ok_i),
    .reset_pin_i(reset_pin_i),
    .poll_cycle_done_i(poll_cycle_done_i),
    .int_n_o(int_n_o),
    .wetting_en_o(wetting_en_o),
    .monitor_en_o(monitor_en_o),
    .link_en_o(link_en_o),
    .trim_load_o(trim_load_o),
    .poll_restart_o(poll_restart_o),
    .baseline_load_o(baseline_load_o),
    .por_flag_o(por_flag_o),
    .fault_flag_o(fault_flag_o)
);

// ### tb/test_switch_monitor_supervisor.sv
`timescale 1ns/1ns
`include "supervisor_regs.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end

module test_switch_monitor_supervisor
    import supervisor_pkg::*;
;
    logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, exp_v;
    logic vdd_ok_i, reset_pin_i, cs_n_i, sclk_i, selfcheck_ok_i;
    logic poll_cycle_done_i, switch_change_i, int_n_o, wetting_en_o, monitor_en_o;
    logic link_en_o, trim_load_o, poll_restart_o, baseline_load_o, por_flag_o, fault_flag_o;
    logic frame, reset_req, pin_req;
    logic [15:0] cfg_v;
    logic [7:0] ccp_v;
    logic [5:0] pin_v;
    supply_ind_type supply_i;
    logic [31:0] exp_q[$];
    int err_total, checks;

    assign pin_v = {int_n_o, por_flag_o, fault_flag_o, monitor_en_o, wetting_en_o, link_en_o};

    switch_monitor_supervisor #(.INIT_CYCLES(4)) DUT (.*);
    switch_host_model host (.clk_i(clk_i), .frame_i(frame), .reset_req_i(reset_req),
        .cs_n_o(cs_n_i), .sclk_o(sclk_i), .reset_pin_o(reset_pin_i));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task wrap_up;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    task idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask : idle

    task xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) err_total++;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : xfer

    task rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        xfer(1'b0, a, 32'h0);
    endtask : rd

    task pins(input logic [5:0] e);
        exp_q.push_back({26'h0, e});
        @(posedge clk_i);
        pin_req <= 1'b1;
        @(posedge clk_i);
        pin_req <= 1'b0;
    endtask : pins

    task wait_por;
        int n;
        n = 0;
        while (por_flag_o !== 1'b1 && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 400) err_total++;
        idle(2);
    endtask : wait_por

    // The cause register is read inside a frame so that the frame end clears it.
    task frame_rd(input logic [31:0] e);
        frame <= 1'b1;
        wait (cs_n_i === 1'b0);
        idle(4);
        rd(`ADDR_CAUSE, e);
        frame <= 1'b0;
        wait (cs_n_i === 1'b1);
        idle(6);
    endtask : frame_rd

    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            exp_v = exp_q.size() ? exp_q.pop_front() : 32'hx;
            `CHK("read data", exp_v, wb_dat_o)
        end
        if (pin_req === 1'b1) begin
            exp_v = exp_q.size() ? exp_q.pop_front() : 32'hx;
            `CHK("pins", exp_v, {26'h0, pin_v})
        end
    end

    // The sequence needs well under 100 us, so 400 us only trips on a hang.
    initial begin
        #400000;
        err_total++;
        wrap_up();
    end

    initial begin
        {rst_i, ce_i, vdd_ok_i, selfcheck_ok_i} = 4'hf;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        {poll_cycle_done_i, switch_change_i, frame, reset_req, pin_req} = '0;
        wb_sel_i = 4'hf;
        supply_i = 4'b0001;
        err_total = 0;
        checks = 0;
        void'($urandom(9));
        cfg_v = 16'($urandom);
        ccp_v = 8'($urandom);
        idle(10);
        rst_i <= 1'b0;
        supply_i <= 4'b1001;
        wait_por();
        pins(6'b010001);
        frame_rd(32'h1);
        pins(6'b100001);
        xfer(1'b1, `ADDR_CFG, {16'h0, cfg_v});
        rd(`ADDR_CFG, {16'h0, cfg_v});
        xfer(1'b1, `ADDR_MAIN, 32'h1);
        pins(6'b100111);
        xfer(1'b1, `ADDR_CFG, {16'h0, ~cfg_v});
        rd(`ADDR_CFG, {16'h0, cfg_v});
        xfer(1'b1, `ADDR_CCP, {24'h0, ccp_v});
        rd(`ADDR_CCP, {24'h0, ccp_v});
        xfer(1'b1, `ADDR_MAIN, 32'h3);
        rd(`ADDR_CRC, {24'h0, cfg_v[15:8] ^ cfg_v[7:0] ^ ccp_v});
        rd(`ADDR_MAIN, 32'h1);
        rd(8'h1c, 32'h0);
        supply_i <= 4'b1010;
        idle(6);
        pins(6'b001001);
        rd(`ADDR_STATUS, 32'h0000_000d);
        frame_rd(32'h4);
        idle(20);
        pins(6'b101001);
        rd(`ADDR_CFG, {16'h0, cfg_v});
        supply_i <= 4'b1001;
        idle(6);
        pins(6'b000111);
        poll_cycle_done_i <= 1'b1;
        @(posedge clk_i);
        poll_cycle_done_i <= 1'b0;
        idle(4);
        frame_rd(32'hc);
        xfer(1'b1, `ADDR_MAIN, 32'h0);
        cfg_v = 16'($urandom);
        xfer(1'b1, `ADDR_CFG, {16'h0, cfg_v});
        rd(`ADDR_CFG, {16'h0, cfg_v});
        vdd_ok_i <= 1'b0;
        idle(5);
        xfer(1'b1, `ADDR_CFG, 32'h0);
        rd(`ADDR_CFG, 32'h0);
        vdd_ok_i <= 1'b1;
        idle(5);
        rd(`ADDR_CFG, {16'h0, cfg_v});
        selfcheck_ok_i <= 1'b0;
        xfer(1'b1, `ADDR_MAIN, 32'h4);
        wait_por();
        frame_rd(32'h3);
        selfcheck_ok_i <= 1'b1;
        xfer(1'b1, `ADDR_MAIN, 32'h4);
        wait_por();
        frame_rd(32'h1);
        rd(`ADDR_CFG, 32'h0);
        xfer(1'b1, `ADDR_CFG, {16'h0, cfg_v});
        reset_req <= 1'b1;
        idle(20);
        pins(6'b100000);
        reset_req <= 1'b0;
        wait_por();
        pins(6'b010001);
        rd(`ADDR_CFG, 32'h0);
        frame_rd(32'h1);
        xfer(1'b1, `ADDR_CFG, {16'h0, cfg_v});
        supply_i <= 4'b1101;
        idle(5);
        supply_i <= 4'b1001;
        wait_por();
        rd(`ADDR_CFG, 32'h0);
        frame_rd(32'h1);
        xfer(1'b1, `ADDR_CFG, {16'h0, cfg_v});
        rd(`ADDR_CFG, {16'h0, cfg_v});
        idle(4);
        wrap_up();
    end
endmodule : test_switch_monitor_supervisor
